/* File: bench/core_model.sv */
// processor core model issuing coprocessor moves and linefill requests
`timescale 1ns/1ps
module core_model (
  input  wire logic        clk_in,
  input  wire logic [31:0] rdata_in,
  input  wire logic        rvalid_in,
  input  wire logic [1:0]  dway_in,
  input  wire logic [1:0]  iway_in,
  output logic             wr_out, rd_out, dreq_out, ireq_out,
  output logic [3:0]       num_out, sel_out,
  output logic [2:0]       op2_out,
  output logic [31:0]      wdata_out
);
  initial begin
    {wr_out, rd_out, dreq_out, ireq_out, num_out, sel_out, op2_out, wdata_out} = '0;
  end
  task automatic move(input logic w, input logic [3:0] n, input logic [3:0] s, input logic [2:0] o,
                      input logic [31:0] d, output logic [31:0] q, output logic v);
    @(negedge clk_in);
    {wr_out, rd_out, num_out, sel_out, op2_out, wdata_out} = {w, !w, n, s, o, d};
    @(negedge clk_in);
    {wr_out, rd_out} = 2'b00;
    // released data must not look like a held value
    wdata_out = ~d;
    q = rdata_in;
    v = rvalid_in;
  endtask
  task automatic fill(input logic i, output logic [1:0] way);
    @(negedge clk_in);
    {ireq_out, dreq_out} = {i, !i};
    @(negedge clk_in);
    {ireq_out, dreq_out} = 2'b00;
    way = i ? iway_in : dway_in;
  endtask
endmodule

/* File: bench/tb_top.sv */
// testbench for translation invalidate and cache way lock
`timescale 1ns/1ps
module tb_top;
  logic        sys_clk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic        cp_write_in, cp_read_in, dfill_req_in, ifill_req_in, cp_rvalid_out, region_sel_out;
  logic        tlb_inv_unpreserved_out, tlb_inv_single_out, dfill_valid_out, ifill_valid_out;
  logic [3:0]  cp_reg_num_in, subregister_select_in, data_cache_way_lock_out, instruction_cache_way_lock_out;
  logic [2:0]  cp_opcode2_in;
  logic [31:0] cp_wdata_in, cp_rdata_out;
  logic [19:0] modified_virtual_address_out;
  logic [1:0]  dfill_way_out, ifill_way_out;
  int          fail_count = 0;
  int          samples_checked = 0;
  always #20 sys_clk_in = ~sys_clk_in;
  tlb_invalidate_cache_way_lock DUT (.*);
  core_model core (.clk_in(sys_clk_in), .rdata_in(cp_rdata_out), .rvalid_in(cp_rvalid_out), .dway_in(dfill_way_out),
    .iway_in(ifill_way_out), .wr_out(cp_write_in), .rd_out(cp_read_in), .dreq_out(dfill_req_in),
    .ireq_out(ifill_req_in), .num_out(cp_reg_num_in), .sel_out(subregister_select_in), .op2_out(cp_opcode2_in),
    .wdata_out(cp_wdata_in));
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic t_inv();
    logic [31:0] q;
    logic        v;
    logic [3:0]  s;
    logic [19:0] m;
    for (int k = 0; k < 3; k++) begin
      s = 4'(12'h756 >> (8 - 4 * k));
      core.move(1'b1, 4'h8, s, 3'h0, 32'h0, q, v);
      chk({tlb_inv_unpreserved_out, tlb_inv_single_out}, 2'b10);
      for (int p = 0; p < 4; p++) begin
        m = {16'h8A40 | 16'(k), 2'(p), 2'b00};
        core.move(1'b1, 4'h8, s, 3'h1, {m, 12'h0}, q, v);
        chk({tlb_inv_unpreserved_out, tlb_inv_single_out, modified_virtual_address_out}, {2'b01, m});
      end
    end
    core.move(1'b1, 4'h8, 4'h7, 3'h2, 32'h0, q, v);
    chk({tlb_inv_unpreserved_out, tlb_inv_single_out}, 2'b00);
    core.move(1'b0, 4'h8, 4'h7, 3'h0, 32'h0, q, v);
    chk(v, 1'b0);
    core.move(1'b0, 4'h9, 4'h1, 3'h0, 32'h0, q, v);
    chk({region_sel_out, v}, 2'b10);
  endtask
  task automatic wl(input logic i, input logic [31:0] d);
    logic [31:0] q;
    logic        v;
    core.move(1'b1, 4'h9, 4'h0, {2'b00, i}, d, q, v);
  endtask
  task automatic t_lock(input logic i);
    logic [31:0] q, r;
    logic        v;
    logic [1:0]  w;
    core.move(1'b0, 4'h9, 4'h0, {2'b00, i}, 32'h0, r, v);
    chk({v, r}, {1'b1, 32'h0000FFF0});
    // keep upper bits as read so the write-back is a true read-modify-write
    wl(i, {r[31:4], 4'hD});
    chk({i ? instruction_cache_way_lock_out : data_cache_way_lock_out, i ? data_cache_way_lock_out :
         instruction_cache_way_lock_out}, 8'hD0);
    repeat (3) begin
      core.fill(i, w);
      chk({i ? ifill_valid_out : dfill_valid_out, w}, 3'h5);
    end
    wl(i, {r[31:4], r[3:0] | 4'h2});
    repeat (4) begin
      core.fill(i, w);
      chk(w == 2'h1, 1'b0);
    end
    wl(i, {r[31:4], 4'h7});
    core.fill(i, w);
    chk(w, 2'h3);
    wl(i, {r[31:4], 4'hF});
    core.fill(i, w);
    chk(w, 2'h3);
    wl(i, {r[31:4], 4'h0});
    core.move(1'b0, 4'h9, 4'h0, {2'b00, i}, 32'h0, q, v);
    chk({v, q}, {1'b1, 32'h0000FFF0});
  endtask
  task automatic t_reset();
    wl(1'b0, 32'h0000FFF5);
    wl(1'b1, 32'h0000FFFA);
    rstn_in = 1'b0;
    @(negedge sys_clk_in);
    rstn_in = 1'b1;
    chk({data_cache_way_lock_out, instruction_cache_way_lock_out}, 8'h00);
  endtask
  initial begin
    repeat (5) @(negedge sys_clk_in);
    rstn_in = 1'b1;
    t_inv();
    t_lock(1'b0);
    t_lock(1'b1);
    t_reset();
    final_report();
  end
  initial begin
    #400000;
    fail_count++;
    final_report();
  end
endmodule
bind tlb_invalidate_cache_way_lock tlb_lock_assertions chk_u (.*);

/* File: bench/tlb_lock_assertions.sv */
// checker for coprocessor maintenance and way lock outputs
`timescale 1ns/1ps
module tlb_lock_assertions (
  input wire logic        sys_clk_in, rstn_in, cp_write_in, cp_read_in, dfill_req_in, ifill_req_in,
  input wire logic [3:0]  cp_reg_num_in, subregister_select_in,
  input wire logic [3:0]  data_cache_way_lock_out, instruction_cache_way_lock_out,
  input wire logic [2:0]  cp_opcode2_in,
  input wire logic [31:0] cp_wdata_in, cp_rdata_out,
  input wire logic [19:0] modified_virtual_address_out,
  input wire logic [1:0]  dfill_way_out, ifill_way_out,
  input wire logic        cp_rvalid_out, region_sel_out, tlb_inv_unpreserved_out, tlb_inv_single_out,
  input wire logic        dfill_valid_out, ifill_valid_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  wire       c8 = cp_write_in && cp_reg_num_in == 4'h8 && subregister_select_in inside {4'h7, 4'h5, 4'h6};
  wire       lk = cp_reg_num_in == 4'h9 && subregister_select_in == 4'h0 && cp_opcode2_in < 3'h2;
  wire [3:0] dl = data_cache_way_lock_out;
  wire [3:0] il = instruction_cache_way_lock_out;
  inv_all_a: assert property (c8 && cp_opcode2_in == 3'h0 |=> tlb_inv_unpreserved_out && !tlb_inv_single_out)
    else $error("set-assoc invalidate missing");
  inv_one_a: assert property (c8 && cp_opcode2_in == 3'h1 |=> tlb_inv_single_out
    && modified_virtual_address_out == $past(cp_wdata_in[31:12])) else $error("single invalidate wrong");
  bad_op_a: assert property (cp_write_in && cp_reg_num_in == 4'h8 && cp_opcode2_in > 3'h1
    |=> !tlb_inv_unpreserved_out && !tlb_inv_single_out) else $error("undefined command acted");
  no_read_a: assert property (cp_read_in && cp_reg_num_in == 4'h8 |=> !cp_rvalid_out)
    else $error("command register answered a read");
  read_fmt_a: assert property (cp_read_in && lk |=> cp_rvalid_out
    && cp_rdata_out == {28'h0000FFF, $past(cp_opcode2_in[0]) ? il : dl}) else $error("lock read wrong");
  dlock_wr_a: assert property (cp_write_in && lk && !cp_opcode2_in[0]
    |=> dl == $past(cp_wdata_in[3:0]) && $stable(il)) else $error("data lock write wrong");
  ilock_wr_a: assert property (cp_write_in && lk && cp_opcode2_in[0]
    |=> il == $past(cp_wdata_in[3:0]) && $stable(dl)) else $error("instruction lock write wrong");
  region_a: assert property ((cp_write_in || cp_read_in) && cp_reg_num_in == 4'h9 && subregister_select_in == 4'h1
    |=> region_sel_out && !cp_rvalid_out) else $error("region select missing");
  dfill_a: assert property (dfill_req_in |=> dfill_valid_out && ($past(dl) == 4'hF ? dfill_way_out == 2'h3
    : (($past(dl) >> dfill_way_out) & 4'h1) == 4'h0)) else $error("data fill way wrong");
  ifill_a: assert property (ifill_req_in |=> ifill_valid_out && ($past(il) == 4'hF ? ifill_way_out == 2'h3
    : (($past(il) >> ifill_way_out) & 4'h1) == 4'h0)) else $error("instruction fill way wrong");
endmodule

/* File: design/tlb_invalidate_cache_way_lock.sv */
// coprocessor register logic for translation-buffer invalidate and cache way lock
//
// Overview of operation
// R1: maintenance command register is write only
// R2: one shared buffer, set-assoc plus lockdown part
// R3: decode exactly six operations from opcode fields
// R4: op2 0 with c7/c5/c6 invalidates set-assoc
// R5: whole invalidate spares lockdown entries
// R6: op2 1 invalidates matching address, any part
// R7: instruction/data variants hit any matching entry
// R8: software invalidates four subpages separately
// R9: lockdown number: c0 cache lock, c1 region
// R10: op2 0 data locks, op2 1 instruction
// R11: bits 3:0 lock bit per way
// R12: linefills go only to unlocked ways
// R13: reset clears all lock bits
// R14: all ways locked means way 3
// R15: software locks at most three ways
// R16: bits 15:4 read ones, 31:16 reserved
// R17: software changes locks by read-modify-write
// R18: software prepares exceptions and storage first
// R19: software unlocks only the target way
// R20: software loads lines by load or prefetch
// R21: software sets target lock, restores others
// R22: software unlocks by clearing the lock bit
`timescale 1ns/1ps
module tlb_invalidate_cache_way_lock (
  input  wire logic        sys_clk_in,
  input  wire logic        rstn_in,
  input  wire logic        cp_write_in,
  input  wire logic        cp_read_in,
  input  wire logic [3:0]  cp_reg_num_in,
  input  wire logic [3:0]  subregister_select_in,
  input  wire logic [2:0]  cp_opcode2_in,
  input  wire logic [31:0] cp_wdata_in,
  input  wire logic        dfill_req_in,
  input  wire logic        ifill_req_in,
  output logic [31:0]      cp_rdata_out,
  output logic             cp_rvalid_out,
  output logic             region_sel_out,
  output logic             tlb_inv_unpreserved_out,
  output logic             tlb_inv_single_out,
  output logic [19:0]      modified_virtual_address_out,
  output logic [3:0]       data_cache_way_lock_out,
  output logic [3:0]       instruction_cache_way_lock_out,
  output logic             dfill_valid_out,
  output logic [1:0]       dfill_way_out,
  output logic             ifill_valid_out,
  output logic [1:0]       ifill_way_out
);

  typedef struct packed {
    logic [31:0] rdata;
    logic        rvalid;
    logic        region_sel;
    logic        inv_all;
    logic        inv_single;
    logic [19:0] inv_addr;
    logic [3:0]  dlock;
    logic [3:0]  ilock;
    logic [1:0]  dcand;
    logic [1:0]  icand;
    logic        dvalid;
    logic [1:0]  dway;
    logic        ivalid;
    logic [1:0]  iway;
  } state_t;

  // every field is named so a new field cannot slip in without a reset value
  localparam state_t STATE_RESET = '{
    rdata:      32'h0000_0000,
    rvalid:     1'b0,
    region_sel: 1'b0,
    inv_all:    1'b0,
    inv_single: 1'b0,
    inv_addr:   20'h0_0000,
    dlock:      tlb_lock_pkg::LOCK_RESET,
    ilock:      tlb_lock_pkg::LOCK_RESET,
    dcand:      2'h0,
    icand:      2'h0,
    dvalid:     1'b0,
    dway:       2'h0,
    ivalid:     1'b0,
    iway:       2'h0
  };

  state_t             state;
  state_t             next_state;
  tlb_lock_pkg::tlb_op_t op;
  way_pick_if         dpick ();
  way_pick_if         ipick ();

  // each cache side has its own picker and its own rotating candidate,
  // so data and instruction fills never disturb each other's rotation
  assign dpick.lock_bits = state.dlock;
  assign dpick.candidate = state.dcand;
  assign ipick.lock_bits = state.ilock;
  assign ipick.candidate = state.icand;

  way_picker u_dpick (
    .port_io (dpick.picker)
  );
  way_picker u_ipick (
    .port_io (ipick.picker)
  );

  // decode of maintenance writes; unlisted combinations do nothing
  always_comb begin
    op = tlb_lock_pkg::OP_NONE;
    if (cp_write_in && cp_reg_num_in == tlb_lock_pkg::REG_TLB_OPS) begin // see R3
      unique case ({cp_opcode2_in, subregister_select_in})
        {tlb_lock_pkg::OP2_ALL, tlb_lock_pkg::SUB_BOTH}:      op = tlb_lock_pkg::OP_INV_ALL;       // see R4
        {tlb_lock_pkg::OP2_ALL, tlb_lock_pkg::SUB_INSTR}:     op = tlb_lock_pkg::OP_INV_INSTR;     // see R4
        {tlb_lock_pkg::OP2_ALL, tlb_lock_pkg::SUB_DATA}:      op = tlb_lock_pkg::OP_INV_DATA;      // see R4
        {tlb_lock_pkg::OP2_SINGLE, tlb_lock_pkg::SUB_BOTH}:   op = tlb_lock_pkg::OP_INV_SINGLE;    // see R6
        {tlb_lock_pkg::OP2_SINGLE, tlb_lock_pkg::SUB_INSTR}:  op = tlb_lock_pkg::OP_INV_SINGLE_I;  // see R6
        {tlb_lock_pkg::OP2_SINGLE, tlb_lock_pkg::SUB_DATA}:   op = tlb_lock_pkg::OP_INV_SINGLE_D;  // see R6
        default:                                              op = tlb_lock_pkg::OP_NONE;
      endcase
    end
  end

  always_comb begin
    next_state            = state;
    next_state.rvalid     = 1'b0;
    next_state.region_sel = 1'b0;
    next_state.dvalid     = 1'b0;
    next_state.ivalid     = 1'b0;
    // invalidate strobes are one-cycle pulses; clearing both here keeps a
    // single invalidate from lingering into a following whole invalidate
    next_state.inv_all    = 1'b0;
    next_state.inv_single = 1'b0;

    // the shared buffer sees one command pulse; lockdown entries only fall to single
    // invalidates, and i/d variants are not filtered by entry origin
    case (op)
      tlb_lock_pkg::OP_INV_ALL, tlb_lock_pkg::OP_INV_INSTR, tlb_lock_pkg::OP_INV_DATA: begin
        next_state.inv_all = 1'b1; // see R2, R5, R7
      end
      tlb_lock_pkg::OP_INV_SINGLE, tlb_lock_pkg::OP_INV_SINGLE_I, tlb_lock_pkg::OP_INV_SINGLE_D: begin
        next_state.inv_single = 1'b1; // see R6, R7
        // only the page address bits matter; the low bits are ignored
        next_state.inv_addr   = cp_wdata_in[tlb_lock_pkg::ADDR_LSB +: tlb_lock_pkg::ADDR_WIDTH];
      end
      default: begin
        next_state.inv_all    = 1'b0;
        next_state.inv_single = 1'b0;
      end
    endcase

    // lockdown number: select picks cache lock bits or the region register;
    // other selects are reserved and are quietly ignored
    if (cp_reg_num_in == tlb_lock_pkg::REG_LOCKDOWN && (cp_write_in || cp_read_in)) begin
      case (subregister_select_in)
        tlb_lock_pkg::SUB_CACHE_LOCK: begin // see R9
          if (cp_write_in) begin
            if (cp_opcode2_in == tlb_lock_pkg::OP2_DATA_LOCK) begin // see R10
              next_state.dlock = cp_wdata_in[tlb_lock_pkg::LOCK_LSB +: tlb_lock_pkg::NUM_WAYS]; // see R11
            end else if (cp_opcode2_in == tlb_lock_pkg::OP2_INSTR_LOCK) begin
              next_state.ilock = cp_wdata_in[tlb_lock_pkg::LOCK_LSB +: tlb_lock_pkg::NUM_WAYS]; // see R11
            end
          end else if (cp_opcode2_in == tlb_lock_pkg::OP2_DATA_LOCK ||
                       cp_opcode2_in == tlb_lock_pkg::OP2_INSTR_LOCK) begin
            next_state.rvalid = 1'b1;
            next_state.rdata  = {tlb_lock_pkg::RESERVED_READ, tlb_lock_pkg::ONES_FIELD,
                                 (cp_opcode2_in == tlb_lock_pkg::OP2_DATA_LOCK) ?
                                 state.dlock : state.ilock}; // see R16
          end
        end
        tlb_lock_pkg::SUB_REGION: begin
          // region register lives elsewhere; flag the access so it can answer
          next_state.region_sel = 1'b1; // see R9
        end
        default: begin
          next_state.region_sel = 1'b0;
        end
      endcase
    end

    // a read of the command register returns nothing defined, so no answer is given
    if (cp_read_in && cp_reg_num_in == tlb_lock_pkg::REG_TLB_OPS) begin // see R1
      next_state.rvalid = 1'b0;
    end

    // fills take the current lock bits; a lock write in the same cycle applies next fill
    // limitation: with all four ways locked every fill lands in the fallback way
    if (dfill_req_in) begin
      next_state.dvalid = 1'b1;
      next_state.dway   = dpick.chosen; // see R12, R14
      next_state.dcand  = 2'(dpick.chosen + 2'h1);
    end
    if (ifill_req_in) begin
      next_state.ivalid = 1'b1;
      next_state.iway   = ipick.chosen; // see R12, R14
      next_state.icand  = 2'(ipick.chosen + 2'h1);
    end
  end

  // single state register; every output below is a plain copy of one field
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= STATE_RESET; // see R13
    end else begin
      state <= next_state;
    end
  end


  // register outputs
  assign cp_rdata_out                   = state.rdata;
  assign cp_rvalid_out                  = state.rvalid;
  assign region_sel_out                 = state.region_sel;
  assign tlb_inv_unpreserved_out        = state.inv_all;
  assign tlb_inv_single_out             = state.inv_single;
  assign modified_virtual_address_out   = state.inv_addr;
  assign data_cache_way_lock_out        = state.dlock;
  assign instruction_cache_way_lock_out = state.ilock;
  assign dfill_valid_out                = state.dvalid;
  assign dfill_way_out                  = state.dway;
  assign ifill_valid_out                = state.ivalid;
  assign ifill_way_out                  = state.iway;
endmodule

/* File: design/tlb_lock_pkg.sv */
// shared constants and types for translation-buffer maintenance and way lockdown
package tlb_lock_pkg;
  localparam int          NUM_WAYS        = 4;
  localparam int          ADDR_WIDTH      = 20;
  localparam logic [3:0]  REG_TLB_OPS     = 4'h8;
  localparam logic [3:0]  REG_LOCKDOWN    = 4'h9;
  localparam logic [3:0]  SUB_BOTH        = 4'h7;
  localparam logic [3:0]  SUB_INSTR       = 4'h5;
  localparam logic [3:0]  SUB_DATA        = 4'h6;
  localparam logic [3:0]  SUB_CACHE_LOCK  = 4'h0;
  localparam logic [3:0]  SUB_REGION      = 4'h1;
  localparam logic [2:0]  OP2_ALL         = 3'h0;
  localparam logic [2:0]  OP2_SINGLE      = 3'h1;
  localparam logic [2:0]  OP2_DATA_LOCK   = 3'h0;
  localparam logic [2:0]  OP2_INSTR_LOCK  = 3'h1;
  localparam int          LOCK_LSB        = 0;
  localparam int          ADDR_LSB        = 12;
  localparam logic [11:0] ONES_FIELD      = 12'hFFF;
  localparam int          ONES_LSB        = 4;
  localparam logic [3:0]  LOCK_RESET      = 4'h0;
  localparam logic [1:0]  FALLBACK_WAY    = 2'h3;
  localparam logic [15:0] RESERVED_READ   = 16'h0000;

  typedef enum logic [2:0] {
    OP_NONE         = 3'b000,
    OP_INV_ALL      = 3'b001,
    OP_INV_INSTR    = 3'b010,
    OP_INV_DATA     = 3'b011,
    OP_INV_SINGLE   = 3'b100,
    OP_INV_SINGLE_I = 3'b101,
    OP_INV_SINGLE_D = 3'b110
  } tlb_op_t;
endpackage

/* File: design/way_pick_if.sv */
// carries lock bits and replacement choice between top and way picker
`timescale 1ns/1ps
interface way_pick_if;
  logic [3:0] lock_bits;
  logic [1:0] candidate;
  logic [1:0] chosen;
  modport picker (input lock_bits, input candidate, output chosen);
  modport owner  (output lock_bits, output candidate, input chosen);
endinterface

/* File: design/way_picker.sv */
// picks the linefill way honouring the lock bits
`timescale 1ns/1ps
module way_picker (
  way_pick_if.picker port_io
);
  logic [1:0] pick;
  logic       found;

  always_comb begin
    pick  = tlb_lock_pkg::FALLBACK_WAY; // see R14
    found = 1'b0;
    // search from the candidate upward so rotation survives partial locking
    for (int i = 0; i < tlb_lock_pkg::NUM_WAYS; i++) begin
      if (!found && !port_io.lock_bits[2'(port_io.candidate + 2'(i))]) begin
        pick  = 2'(port_io.candidate + 2'(i)); // see R12
        found = 1'b1;
      end
    end
  end

  assign port_io.chosen = pick;
endmodule
